// ---- gpsp_cfg.svh ----
// Purpose: constants of the pin port, interrupt line and serial control port
// Assumes: 25 MHz system clock
// Notes: offsets are serial port addresses, commands are write command numbers
`ifndef GPSP_CFG_SVH
`define GPSP_CFG_SVH
`define GPSP_ADDR_WRITE 8'hE8
`define GPSP_ADDR_IRQ 8'hEA
`define GPSP_ADDR_FS 8'hEB
`define GPSP_ADDR_CS 8'hEC
`define GPSP_ADDR_PC 8'hED
`define GPSP_CMD_SYS1 4'h0
`define GPSP_CMD_SRCSW 4'h5
`define GPSP_CMD_IRQSEL 4'h8
`define GPSP_CMD_PINOUT 4'hA
`define GPSP_CMD_DATAIO2 4'hD
`define GPSP_BIT_DOEN 1
`define GPSP_BIT_OUT_CLOCK_SOURCE_SEL 1
`define GPSP_BIT_PIN_INPUT_FUNCTION_SEL 0
`define GPSP_BIT_EXTERNAL_ROUTE_SEL 1
`define GPSP_BIT_EXT_MCLK_INVERT 2
`define GPSP_BIT_EXT_DATA_MUTE 3
`define GPSP_SRC_ERROR 0
`define GPSP_SRC_AUDIO 4
`define GPSP_SRC_PIN 6
`define GPSP_WRITE_BITS 5'h10
`define GPSP_CLK_HZ 25000000
`define GPSP_TICK_HZ 24000
`define GPSP_TICK_CYCLES (`GPSP_CLK_HZ / `GPSP_TICK_HZ)
`endif

// ---- gpsp_pkg.sv ----
// Purpose: types shared by the pin port files
// Assumes: nothing
// Notes: one struct holds all state of the sampler and one all state of the port
package gpsp_pkg;
	typedef enum logic [1:0] {GPSP_ADDR, GPSP_WDATA, GPSP_RDATA, GPSP_SKIP} gpsp_phase_e;
	typedef struct packed {
		logic mck;
		logic bck;
		logic lrck;
		logic data;
	} gpsp_clk_src_s;
	typedef struct packed {
		logic [3:0] s1;
		logic [3:0] s2;
		logic [10:0] cnt;
		logic tick;
	} gpsp_smp_s;
	typedef struct packed {
		gpsp_phase_e phase;
		logic ce_q;
		logic cl_q;
		logic [7:0] addr_sh;
		logic [15:0] wr_sh;
		logic [4:0] bit_cnt;
		logic [15:0] rd_sh;
		logic [7:0] rd_addr;
		logic dout_en;
		logic doen_off;
		logic out_clock_source_sel;
		logic [7:0] irq_en;
		logic [3:0] pin_out;
		logic [3:0] dataio2;
		logic [7:0] flags;
		logic [3:0] pin_reg;
		logic [3:0] pin_ref;
		logic frozen;
		logic fault_q;
		logic audio_q;
		logic strap_done;
		logic in_mode;
		gpsp_clk_src_s sel;
		logic irq_act;
	} gpsp_state_s;
endpackage

// ---- gpsp_pin_sampler.sv ----
// Purpose: pin synchroniser and 24 kHz sampling tick
// Assumes: one clock
// Notes: tick is a one-cycle enable pulse
`timescale 1ns/1ps
`default_nettype none
`include "gpsp_cfg.svh"
module gpsp_pin_sampler #(
	parameter int TICK_CYCLES = `GPSP_TICK_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [3:0] pin_raw,
	output logic [3:0] pin_sync,
	output logic tick
);
	gpsp_pkg::gpsp_smp_s s, n;

	// two-stage synchroniser, divider for the tick
	always_comb begin
		n = s;
		n.s1 = pin_raw;
		n.s2 = s.s1; // [R25]
		n.tick = 1'b0;
		if (s.cnt == 11'(TICK_CYCLES - 1)) begin
			n.cnt = 11'h000;
			n.tick = 1'b1; // [R6]
		end else begin
			n.cnt = s.cnt + 11'h001;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign pin_sync = s.s2;
	assign tick = s.tick;
endmodule
`default_nettype wire

// ---- gpsp_port.sv ----
// Purpose: four-pin user port, interrupt line and serial control port
// Assumes: all pins synchronous to clk_sys; strobes far slower than clk_sys
// Notes: direction of the user pins is strapped by the interrupt line pull
// Functional notes
// [R1] output mode drives pins from host data
// [R2] pin values from command 10 upper nibble
// [R3] input, function select clear: pins captured
// [R4] input, function select set: pins feed selector
// [R5] captured pins read in low nibble
// [R6] pin-change enabled: sample on 24 kHz tick
// [R7] pin change drops interrupt, capture re-updates
// [R8] interrupt-register read releases line, freezes capture
// [R9] reading captured pins clears them
// [R10] pin-change disabled: sample at read address
// [R11] selector routes pins, PLL or oscillator
// [R12] external select only with function select
// [R13] clock invert and data mute need select
// [R14] host sets selector only in master
// [R15] interrupt idles high, low on event
// [R16] interrupt is OR of enabled sources
// [R17] eight interrupt sources
// [R18] source flags latched; error, audio live
// [R19] host keeps oscillator running for sources
// [R20] only interrupt-register read clears line; a command 8 write that disables the flagged source also releases it
// [R21] LSB first, address then data
// [R22] one write and four read addresses
// [R23] host write frame layout
// [R24] data out driven between strobe edges
// [R25] pins synchronised before change detection
`timescale 1ns/1ps
`default_nettype none
`include "gpsp_cfg.svh"
module gpsp_port #(
	parameter int TICK_CYCLES = `GPSP_TICK_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic shift_strobe_line,
	input wire logic frame_strobe,
	input wire logic serial_in_line,
	output logic dout_out,
	output logic dout_oe_n,
	input wire logic [1:0] chip_addr,
	input wire logic irq_n_in,
	output logic irq_n_out,
	output logic irq_n_oe_n,
	input wire logic [3:0] user_pin_in,
	output logic [3:0] user_pin_out,
	output logic [3:0] user_pin_oe_n,
	input wire logic pll_locked,
	input wire gpsp_pkg::gpsp_clk_src_s pll_src,
	input wire gpsp_pkg::gpsp_clk_src_s osc_src,
	input wire logic aux_serial_audio_in,
	output logic rx_master_clock_out,
	output logic rx_bit_clock_out,
	output logic rx_frame_clock_out,
	output logic rx_data_out,
	input wire logic receive_fault_pin,
	input wire logic nonaudio_flag_src,
	input wire logic input_detect_src,
	input wire logic rate_change_src,
	input wire logic chan_status_update_src,
	input wire logic burst_pc_update_src,
	input wire logic emph_change_src,
	input wire logic [7:0] detect_status,
	input wire logic [11:0] fs_status,
	input wire logic [15:0] chan_status_word,
	input wire logic [15:0] burst_pc_word
);
	gpsp_pkg::gpsp_state_s s, n;
	logic [3:0] pin_sync;
	logic tick;
	logic ce_rise, ce_fall, cl_rise, cl_fall;
	logic pin_mode, pin_irq_mode, ext_on, use_pll, pin_change;
	logic irq_rd_now;
	logic [7:0] events;

	gpsp_pin_sampler #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_smp (
		.clk_sys(clk_sys),
		.rst(rst),
		.pin_raw(user_pin_in),
		.pin_sync(pin_sync),
		.tick(tick)
	);

	// read addresses; no address serves both directions
	function automatic logic is_read(input logic [7:0] a);
		is_read = (a == `GPSP_ADDR_IRQ) || (a == `GPSP_ADDR_FS) ||
			(a == `GPSP_ADDR_CS) || (a == `GPSP_ADDR_PC); // [R22]
	endfunction

	// word loaded into the output shifter at the start of a read
	function automatic logic [15:0] read_word(input logic [7:0] a,
		input gpsp_pkg::gpsp_state_s st, input logic [3:0] pins);
		logic [7:0] f;
		f = st.flags;
		f[`GPSP_SRC_ERROR] = receive_fault_pin; // [R18]
		f[`GPSP_SRC_AUDIO] = nonaudio_flag_src; // [R18]
		if (a == `GPSP_ADDR_IRQ) begin
			read_word = {f, detect_status};
		end else if (a == `GPSP_ADDR_FS) begin
			read_word = {fs_status, pins}; // [R5]
		end else if (a == `GPSP_ADDR_CS) begin
			read_word = chan_status_word;
		end else if (a == `GPSP_ADDR_PC) begin
			read_word = burst_pc_word;
		end else begin
			read_word = 16'h0000;
		end
	endfunction

	// strobe edges and mode decode
	always_comb begin
		ce_rise = frame_strobe & ~s.ce_q;
		ce_fall = ~frame_strobe & s.ce_q;
		cl_rise = shift_strobe_line & ~s.cl_q;
		cl_fall = ~shift_strobe_line & s.cl_q;
		pin_mode = s.strap_done & s.in_mode & ~s.dataio2[`GPSP_BIT_PIN_INPUT_FUNCTION_SEL];
		pin_irq_mode = pin_mode & s.irq_en[`GPSP_SRC_PIN];
		ext_on = s.in_mode & s.dataio2[`GPSP_BIT_PIN_INPUT_FUNCTION_SEL] & s.dataio2[`GPSP_BIT_EXTERNAL_ROUTE_SEL];
		use_pll = pll_locked & ~s.out_clock_source_sel;
		pin_change = tick & (pin_sync != s.pin_ref);
		irq_rd_now = s.phase == gpsp_pkg::GPSP_ADDR && ce_rise && s.addr_sh == `GPSP_ADDR_IRQ;
	end

	// source events in flag order
	always_comb begin
		events = 8'h00;
		events[0] = receive_fault_pin ^ s.fault_q; // [R17]
		events[1] = input_detect_src;
		events[2] = rate_change_src;
		events[3] = chan_status_update_src;
		events[4] = nonaudio_flag_src ^ s.audio_q;
		events[5] = burst_pc_update_src;
		events[6] = pin_irq_mode & pin_change & ~s.frozen; // [R7]
		events[7] = emph_change_src;
	end

	// next state: serial engine, capture, flags, selector
	always_comb begin
		n = s;
		n.ce_q = frame_strobe;
		n.cl_q = shift_strobe_line;
		n.fault_q = receive_fault_pin;
		n.audio_q = nonaudio_flag_src;
		if (!s.strap_done) begin
			n.strap_done = 1'b1;
			n.in_mode = ~irq_n_in; // pulled low means input mode
		end
		// change reference follows the pins on every tick
		if (tick) begin
			n.pin_ref = pin_sync; // [R6]
		end
		case (s.phase)
			gpsp_pkg::GPSP_ADDR: begin
				if (!frame_strobe && cl_rise) begin
					n.addr_sh = {serial_in_line, s.addr_sh[7:1]}; // [R21]
				end
				if (ce_rise) begin
					n.bit_cnt = 5'h00;
					n.rd_addr = s.addr_sh;
					if (s.addr_sh == `GPSP_ADDR_WRITE) begin
						n.phase = gpsp_pkg::GPSP_WDATA;
					end else if (is_read(s.addr_sh)) begin
						n.phase = gpsp_pkg::GPSP_RDATA;
						n.dout_en = ~s.doen_off; // [R24]
						if (s.addr_sh == `GPSP_ADDR_FS && pin_mode && !pin_irq_mode) begin
							n.pin_reg = pin_sync; // [R10]
							n.rd_sh = read_word(s.addr_sh, s, pin_sync);
						end else begin
							n.rd_sh = read_word(s.addr_sh, s, s.pin_reg);
						end
						if (s.addr_sh == `GPSP_ADDR_IRQ) begin
							n.flags = 8'h00; // [R8] [R20]
							n.frozen = pin_irq_mode; // [R8]
						end
					end else begin
						n.phase = gpsp_pkg::GPSP_SKIP;
					end
				end
			end
			gpsp_pkg::GPSP_WDATA: begin
				if (cl_rise && s.bit_cnt != 5'h1F) begin
					n.wr_sh = {serial_in_line, s.wr_sh[15:1]}; // [R21]
					n.bit_cnt = s.bit_cnt + 5'h01;
				end
				if (ce_fall) begin
					n.phase = gpsp_pkg::GPSP_ADDR;
					if (s.bit_cnt == `GPSP_WRITE_BITS && s.wr_sh[1:0] == chip_addr) begin
						if (s.wr_sh[7:4] == `GPSP_CMD_SYS1) begin
							n.doen_off = s.wr_sh[8 + `GPSP_BIT_DOEN];
						end else if (s.wr_sh[7:4] == `GPSP_CMD_SRCSW) begin
							n.out_clock_source_sel = s.wr_sh[8 + `GPSP_BIT_OUT_CLOCK_SOURCE_SEL];
						end else if (s.wr_sh[7:4] == `GPSP_CMD_IRQSEL) begin
							n.irq_en = s.wr_sh[15:8]; // [R16]
						end else if (s.wr_sh[7:4] == `GPSP_CMD_PINOUT) begin
							n.pin_out = s.wr_sh[15:12]; // [R2]
						end else if (s.wr_sh[7:4] == `GPSP_CMD_DATAIO2) begin
							n.dataio2 = s.wr_sh[11:8];
						end
					end
				end
			end
			gpsp_pkg::GPSP_RDATA: begin
				if (cl_fall) begin
					n.rd_sh = {1'b0, s.rd_sh[15:1]}; // [R21]
				end
				if (ce_fall) begin
					n.phase = gpsp_pkg::GPSP_ADDR;
					n.dout_en = 1'b0; // [R24]
					if (s.rd_addr == `GPSP_ADDR_FS) begin
						n.pin_reg = 4'h0; // [R9]
						n.frozen = 1'b0;
					end
				end
			end
			default: begin
				if (ce_fall) begin
					n.phase = gpsp_pkg::GPSP_ADDR;
				end
			end
		endcase
		// a pin capture in the clearing cycle is kept, as with the flags
		if (events[`GPSP_SRC_PIN]) begin
			n.pin_reg = pin_sync; // [R3] [R7]
		end
		// a source that fires in the clearing cycle is kept
		n.flags = n.flags | (events & s.irq_en); // [R17] [R18]
		n.irq_act = |(n.flags & n.irq_en); // [R15] [R16]
		// selector, external routing only with function select
		if (ext_on) begin
			n.sel.mck = user_pin_in[0] ^ s.dataio2[`GPSP_BIT_EXT_MCLK_INVERT]; // [R11] [R13]
			n.sel.bck = user_pin_in[1]; // [R4]
			n.sel.lrck = user_pin_in[2];
			n.sel.data = user_pin_in[3] & ~s.dataio2[`GPSP_BIT_EXT_DATA_MUTE]; // [R13]
		end else if (use_pll) begin
			n.sel = pll_src; // [R12]
		end else begin
			n.sel = osc_src;
			n.sel.data = aux_serial_audio_in; // [R11]
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	// pin and line drivers; nothing driven until the strap is caught
	assign user_pin_out = s.pin_out; // [R1] [R2]
	assign user_pin_oe_n = {4{~(s.strap_done & ~s.in_mode)}}; // [R1]
	assign irq_n_out = ~s.irq_act; // [R15]
	assign irq_n_oe_n = ~s.strap_done;
	assign dout_out = s.rd_sh[0];
	assign dout_oe_n = ~s.dout_en;
	assign rx_master_clock_out = s.sel.mck;
	assign rx_bit_clock_out = s.sel.bck;
	assign rx_frame_clock_out = s.sel.lrck;
	assign rx_data_out = s.sel.data;

	// interrupt-register read taken at the strobe rise
	sequence s_irq_read;
		s.phase == gpsp_pkg::GPSP_ADDR && ce_rise && s.addr_sh == `GPSP_ADDR_IRQ;
	endsequence

	sequence s_fs_read_end;
		s.phase == gpsp_pkg::GPSP_RDATA && ce_fall && s.rd_addr == `GPSP_ADDR_FS;
	endsequence

	a_irq_read_release: assert property (@(posedge clk_sys) disable iff (rst) // [R8]
		s_irq_read and (events == 8'h00) |=> irq_n_out)
		else $error("interrupt not released by read");
	a_irq_only_read: assert property (@(posedge clk_sys) disable iff (rst) // [R20]
		$rose(irq_n_out) |-> $past(irq_rd_now))
		else $error("interrupt released without read");
	a_src_drops_irq: assert property (@(posedge clk_sys) disable iff (rst) // [R16]
		rate_change_src && s.irq_en[2] |=> !irq_n_out && s.flags[2])
		else $error("enabled source did not drop interrupt");
	a_disabled_src: assert property (@(posedge clk_sys) disable iff (rst) // [R16]
		s.irq_en == 8'h00 && !(s.phase == gpsp_pkg::GPSP_WDATA && ce_fall) |=> irq_n_out)
		else $error("interrupt low with no source enabled");
	a_pin_change_irq: assert property (@(posedge clk_sys) disable iff (rst) // [R7]
		pin_irq_mode && pin_change && !s.frozen |=> s.flags[6] && s.pin_reg == $past(pin_sync))
		else $error("pin change not captured");
	a_frozen_hold: assert property (@(posedge clk_sys) disable iff (rst) // [R8]
		s.frozen && !(s.phase == gpsp_pkg::GPSP_RDATA && ce_fall) |=> $stable(s.pin_reg))
		else $error("frozen capture changed");
	a_fs_read_clear: assert property (@(posedge clk_sys) disable iff (rst) // [R9]
		s_fs_read_end and !events[`GPSP_SRC_PIN] |=> s.pin_reg == 4'h0 && !s.frozen)
		else $error("capture not cleared after read");
	a_dout_release: assert property (@(posedge clk_sys) disable iff (rst) // [R24]
		ce_fall |=> dout_oe_n ##1 dout_oe_n)
		else $error("data out driven after strobe fall");
	a_pin_write: assert property (@(posedge clk_sys) disable iff (rst) // [R2]
		s.phase == gpsp_pkg::GPSP_WDATA && ce_fall && s.bit_cnt == `GPSP_WRITE_BITS &&
		s.wr_sh[1:0] == chip_addr && s.wr_sh[7:4] == `GPSP_CMD_PINOUT
		|=> user_pin_out == $past(s.wr_sh[15:12]))
		else $error("pin output not updated by write");
	a_sel_external: assert property (@(posedge clk_sys) disable iff (rst) // [R11]
		ext_on |=> rx_bit_clock_out == $past(user_pin_in[1]) &&
		rx_frame_clock_out == $past(user_pin_in[2]))
		else $error("selector not routing pins");
	a_sel_internal: assert property (@(posedge clk_sys) disable iff (rst) // [R12]
		!ext_on && !use_pll |=> rx_data_out == $past(aux_serial_audio_in) &&
		rx_master_clock_out == $past(osc_src.mck))
		else $error("selector not routing oscillator side");
endmodule
`default_nettype wire

// ---- gpsp_host.sv ----
// Purpose: host model driving the serial control port
// Assumes: shift line idles low; each level held for several clk_sys cycles
// Notes: the testbench calls the wr and rd tasks
`timescale 1ns/1ps
`default_nettype none
module gpsp_host (
	output logic shift_strobe_line,
	output logic frame_strobe,
	output logic serial_in_line,
	input wire logic clk_sys,
	input wire logic dout_out,
	input wire logic dout_oe_n
);
	logic last_b;
	// idle levels at time zero
	initial begin
		shift_strobe_line = 1'b0;
		frame_strobe = 1'b0;
		serial_in_line = 1'b0;
		last_b = 1'b0;
	end
	// wait a number of clock edges
	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// one bit, shift line high two cycles then low three
	task automatic send_bit(input logic b);
		serial_in_line <= b;
		shift_strobe_line <= 1'b1;
		wt(2);
		shift_strobe_line <= 1'b0;
		wt(3);
	endtask
	// address byte with strobe low, lsb first, then strobe high
	task automatic send_addr(input logic [7:0] a);
		frame_strobe <= 1'b0;
		wt(3);
		for (int i = 0; i < 8; i++) send_bit(a[i]);
		frame_strobe <= 1'b1;
		wt(3);
	endtask
	// strobe low ends the frame; data line no longer shows its last bit
	task automatic end_frame();
		frame_strobe <= 1'b0;
		serial_in_line <= ~serial_in_line;
		wt(3);
	endtask
	// write word: chip bits, two zero bits, command, data
	task automatic wr(input logic [1:0] chip, input logic [3:0] cmd, input logic [7:0] dat);
		logic [15:0] w;
		w = {dat, cmd, 2'b00, chip};
		send_addr(8'hE8);
		for (int i = 0; i < 16; i++) send_bit(w[i]);
		end_frame();
	endtask
	// read word: each bit taken before the shift pulse that advances it
	task automatic rd(input logic [7:0] a, output logic [15:0] dat, output logic oe_n);
		send_addr(a);
		oe_n = dout_oe_n;
		for (int i = 0; i < 16; i++) begin
			dat[i] = dout_oe_n ? ~last_b : dout_out; // released line shows no stale level
			last_b = dat[i];
			send_bit(1'b0);
		end
		end_frame();
	endtask
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Purpose: self-checking bench of the pin port, interrupt line and serial port
// Assumes: host model gpsp_host; sampling tick shortened to 8 cycles
// Notes: the interrupt wire pull picks the pin direction at each reset
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk_sys, rst, pull, pll_locked, aux, oe;
	logic [7:0] src;
	logic [3:0] pin_drv;
	logic [1:0] chip;
	logic [7:0] det_st;
	logic [11:0] fs_st;
	logic [15:0] cs_w, pc_w;
	logic [15:0] d;
	int n_mismatch, checked, cyc;
	logic [7:0] c13 [5] = '{8'h03, 8'h07, 8'h0B, 8'h0E, 8'h0E};
	logic [3:0] sx [5] = '{4'h9, 4'h1, 4'h8, 4'h6, 4'hB};
	wire logic shift_l, frame_l, sdi, dout, dout_oe_n, irq_out, irq_oe_n, irq_w;
	wire logic mck, bck, lrck, rdat;
	wire logic [3:0] pin_out, pin_oe_n, pin_w;
	gpsp_pkg::gpsp_clk_src_s pll_src, osc_src;
	// wire levels from every party's enable
	assign irq_w = irq_oe_n ? pull : irq_out;
	assign pin_w = (pin_oe_n & pin_drv) | (~pin_oe_n & pin_out);
	gpsp_host host_u (.clk_sys(clk_sys), .shift_strobe_line(shift_l), .frame_strobe(frame_l),
		.serial_in_line(sdi), .dout_out(dout), .dout_oe_n(dout_oe_n));
	gpsp_port #(.TICK_CYCLES(8)) dut_u (.clk_sys(clk_sys), .rst(rst),
		.shift_strobe_line(shift_l), .frame_strobe(frame_l), .serial_in_line(sdi),
		.dout_out(dout), .dout_oe_n(dout_oe_n), .chip_addr(chip), .irq_n_in(irq_w),
		.irq_n_out(irq_out), .irq_n_oe_n(irq_oe_n), .user_pin_in(pin_w),
		.user_pin_out(pin_out), .user_pin_oe_n(pin_oe_n), .pll_locked(pll_locked),
		.pll_src(pll_src), .osc_src(osc_src), .aux_serial_audio_in(aux),
		.rx_master_clock_out(mck), .rx_bit_clock_out(bck), .rx_frame_clock_out(lrck),
		.rx_data_out(rdat), .receive_fault_pin(src[0]), .input_detect_src(src[1]),
		.rate_change_src(src[2]), .chan_status_update_src(src[3]),
		.nonaudio_flag_src(src[4]), .burst_pc_update_src(src[5]), .emph_change_src(src[7]),
		.detect_status(det_st), .fs_status(fs_st), .chan_status_word(cs_w),
		.burst_pc_word(pc_w));
	// compare one value, report and count a mismatch
	task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
		checked++;
		if (s !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	// counts, verdict and end of run
	task automatic print_verdict();
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// reset held 20 cycles with the chosen pull on the interrupt wire
	task automatic do_reset(input logic p);
		pull <= p;
		rst <= 1'b1;
		repeat (20) @(posedge clk_sys);
		chk("irq_n_out", 16'(irq_out), 16'h1);
		chk("dout_oe_n", 16'(dout_oe_n), 16'h1);
		rst <= 1'b0;
		repeat (4) @(posedge clk_sys);
		chk("irq oe", 16'(irq_oe_n), 16'h0);
	endtask
	// clock of 40 ns
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	// hang guard
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 60000) begin
			n_mismatch++;
			print_verdict();
		end
	end
	// main sequence
	initial begin
		rst = 1'b1;
		pull = 1'b1;
		pll_locked = 1'b1;
		aux = 1'b1;
		src = 8'h00;
		pin_drv = 4'h0;
		chip = 2'h2;
		pll_src = 4'h6;
		osc_src = 4'hA; // oscillator side runs throughout
		det_st = 8'h5A;
		fs_st = 12'hABC;
		cs_w = 16'h1234;
		pc_w = 16'hC0DE;
		n_mismatch = 0;
		checked = 0;
		cyc = 0;
		do_reset(1'b1);
		chk("pin oe", 16'(pin_oe_n), 16'h0);
		host_u.wr(chip, 4'hA, 8'h50);
		chk("pin out", 16'(pin_out), 16'h5);
		host_u.wr(~chip, 4'hA, 8'hF0);
		chk("pin out", 16'(pin_out), 16'h5);
		host_u.rd(8'hE9, d, oe);
		chk("unmapped oe", 16'(oe), 16'h1);
		host_u.rd(8'hED, d, oe);
		chk("pc word", d, 16'hC0DE);
		chk("read oe", 16'(oe), 16'h0);
		chk("dout_oe_n", 16'(dout_oe_n), 16'h1);
		host_u.rd(8'hEB, d, oe);
		chk("fs bits", 16'(d[15:4]), 16'hABC);
		pc_w <= 16'h0F1E;
		host_u.rd(8'hED, d, oe);
		chk("pc word", d, 16'h0F1E);
		host_u.wr(chip, 4'h0, 8'h02);
		host_u.rd(8'hEC, d, oe);
		chk("disabled oe", 16'(oe), 16'h1);
		host_u.wr(chip, 4'h0, 8'h00);
		$display("test output and port done");
		for (int k = 0; k < 8; k++) begin
			if (k != 6) begin
				host_u.wr(chip, 4'h8, 8'h01 << k);
				host_u.rd(8'hEA, d, oe);
				src[k] <= ~src[k];
				@(posedge clk_sys);
				if (k != 0 && k != 4) src[k] <= 1'b0;
				repeat (3) @(posedge clk_sys);
				chk("irq_n_out", 16'(irq_out), 16'h0);
				cs_w <= 16'h1234 ^ 16'(k);
				host_u.rd(8'hEC, d, oe);
				chk("cs word", d, 16'h1234 ^ 16'(k));
				chk("irq_n_out", 16'(irq_out), 16'h0);
				host_u.rd(8'hEA, d, oe);
				chk("flags", d, {(8'h01 << k) & 8'hEE | {3'h0, src[4], 3'h0, src[0]}, 8'h5A});
				chk("irq_n_out", 16'(irq_out), 16'h1);
			end
		end
		host_u.wr(chip, 4'h8, 8'h00);
		host_u.rd(8'hEA, d, oe);
		src[0] <= ~src[0];
		repeat (4) @(posedge clk_sys);
		chk("irq_n_out", 16'(irq_out), 16'h1);
		$display("test interrupt sources done");
		pin_drv <= 4'h5;
		do_reset(1'b0);
		chk("pin oe", 16'(pin_oe_n), 16'hF);
		fs_st <= 12'h123;
		det_st <= 8'hA5;
		host_u.rd(8'hEB, d, oe);
		chk("pins", 16'(d[3:0]), 16'h5);
		chk("fs bits", 16'(d[15:4]), 16'h123);
		pin_drv <= 4'hA;
		host_u.rd(8'hEB, d, oe);
		chk("pins", 16'(d[3:0]), 16'hA);
		host_u.wr(chip, 4'h8, 8'h40);
		host_u.wt(40);
		host_u.rd(8'hEA, d, oe);
		host_u.rd(8'hEB, d, oe);
		host_u.rd(8'hEB, d, oe);
		chk("cleared pins", 16'(d[3:0]), 16'h0);
		pin_drv <= 4'h3;
		host_u.wt(40);
		chk("irq_n_out", 16'(irq_out), 16'h0);
		pin_drv <= 4'h6;
		host_u.wt(40);
		host_u.rd(8'hEA, d, oe);
		chk("pin flag", 16'(d[14]), 16'h1);
		chk("detect bits", 16'(d[7:0]), 16'hA5);
		chk("irq_n_out", 16'(irq_out), 16'h1);
		pin_drv <= 4'hC;
		host_u.wt(40);
		host_u.rd(8'hEB, d, oe);
		chk("frozen pins", 16'(d[3:0]), 16'h6);
		host_u.wr(chip, 4'h8, 8'h00);
		$display("test pin capture done");
		pin_drv <= 4'h9;
		// selector settings are written in master mode only
		for (int i = 0; i < 5; i++) begin
			pll_locked <= (i != 4);
			host_u.wr(chip, 4'hD, c13[i]);
			chk("selector", 16'({mck, bck, lrck, rdat}), 16'(sx[i]));
		end
		// locked but output clock source forced to the oscillator side
		pll_locked <= 1'b1;
		aux <= 1'b0;
		host_u.wr(chip, 4'h5, 8'h02);
		chk("selector", 16'({mck, bck, lrck, rdat}), 16'hA);
		$display("test selector done");
		print_verdict();
	end
endmodule
`default_nettype wire
